// ---- design/vwc_ctrl.sv ----
// controller that drives write-type ram cycles of a multiport video dram
// assumes all pins are sampled/driven on sys_clk; the dram has no clock on its ram port
// Operation
// - flag low at both falls, we low at row fall: masked write
// - flag low at row, high at column, we low: masked block write
// - flag low at both falls, we high: plain write, row-fall data ignored
// - flag low at row, high at column, we high: plain block write
// - after power-up wait 100 us then run eight or more cycles
// - use refresh-with-register-clear for the initialisation cycles
// - give one serial clock after power-up so the output flag is valid
// - hold the reserved function flag low always
// - never choose a split start address on a boundary
// - turn device outputs off by column strobe or oe before driving data
// - release data drivers before device output buffers turn on
`default_nettype none
module vwc_ctrl #(
    parameter int unsigned PWRUP_CYCLES = vwc_pkg::PWRUP_CYC
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // user order port
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire vwc_pkg::vwc_req_t req,
    output logic                   done,
    output logic [7:0]             rd_data,
    output logic                   init_done,
    // dram pins: ram port, plus serial clock and serial port enable
    output logic                   row_strobe_n,
    output logic                   col_strobe_n,
    output logic                   write_enable_n,
    output logic                   transfer_output_enable_n,
    output logic                   function_flag_in,
    output logic                   reserved_function_flag,
    output logic                   serial_clock,
    output logic                   serial_port_enable_n,
    output logic [8:0]             addr,
    input  wire logic [7:0]        dq_in,
    output logic [7:0]             dq_out,
    output logic                   dq_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    import vwc_pkg::*;

    vwc_state_t  st_q, st_d;
    logic [11:0] cnt_q, cnt_d;       // power-up and phase counter
    logic [3:0]  ninit_q, ninit_d;   // initialisation cycles issued
    vwc_req_t    r_q, r_d;
    vwc_code_t   code;
    logic        ras_q, ras_d, cas_q, cas_d, we_q, we_d, oe_q, oe_d, fl_q, fl_d;
    logic        sc_q, sc_d, doe_q, doe_d, done_q, done_d;
    logic [8:0]  a_q, a_d;
    logic [7:0]  do_q, do_d, rd_q, rd_d;

    vwc_code_rom u_rom (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .cmd     (r_q.cmd),
        .code    (code)
    );

    function automatic logic phase_end(input logic [11:0] c);
        return c == 12'(PH_CYC - 1);
    endfunction

    // cycle sequencer: init pause, then row, column, data, precharge
    always_comb begin
        st_d = st_q; cnt_d = cnt_q + 12'h001; ninit_d = ninit_q; r_d = r_q;
        ras_d = ras_q; cas_d = cas_q; we_d = we_q; oe_d = oe_q; fl_d = fl_q;
        sc_d = sc_q; doe_d = doe_q; a_d = a_q; do_d = do_q; rd_d = rd_q;
        done_d = 1'b0;
        case (st_q)
            VWC_S_INIT: begin
                // counter is sized for the default; shorter values still fit
                if (cnt_q >= 12'(PWRUP_CYCLES - 1)) begin
                    st_d = VWC_S_SCLK; cnt_d = '0; sc_d = 1'b1;
                end
            end
            VWC_S_SCLK: begin
                sc_d = 1'b0;
                if (phase_end(cnt_q)) begin
                    // refresh with register clear: column before row, we high, flag low
                    r_d.cmd = VWC_REFRESH_CLEAR;
                    cas_d = 1'b0; we_d = 1'b1; fl_d = 1'b0;
                    st_d = VWC_S_ROW; cnt_d = '0;
                end
            end
            VWC_S_IDLE: begin
                if (req_valid) begin
                    r_d = req; st_d = VWC_S_ROW; cnt_d = '0;
                    // row phase setup; rom code is valid two cycles later, one after r_q loads
                    // output enable high at row fall, or the device decodes a transfer
                    a_d = req.row; oe_d = 1'b1;
                    if (req.cmd == VWC_REFRESH_CLEAR) begin
                        // column falls first so the device sees a clearing refresh
                        cas_d = 1'b0; fl_d = 1'b0;
                    end
                    // we level at row fall: low selects a masked write, high a plain one
                    we_d = !(req.cmd inside {VWC_MASKED_WRITE, VWC_MASKED_BLOCK_WRITE});
                    // new mask goes out at row fall, persistent leaves pins off
                    doe_d = req.new_mask && !we_d;
                    do_d = req.mask;
                end
            end
            VWC_S_ROW: begin
                if (r_q.cmd != VWC_REFRESH_CLEAR) begin
                    fl_d = code.flag_row;
                end
                if (cnt_q == 12'h001) begin
                    ras_d = 1'b0;  // row fall: flag, we and mask sampled
                end
                if (cnt_q == 12'h002) begin
                    cnt_d = '0;
                    if (r_q.cmd == VWC_REFRESH_CLEAR) begin
                        st_d = VWC_S_PRE;
                    end else begin
                        st_d = VWC_S_COL;
                        a_d = r_q.col; fl_d = code.flag_col;
                        doe_d = 1'b0;   // mask released before data phase
                        we_d = code.we_row_n;
                    end
                end
            end
            VWC_S_COL: begin
                if (cnt_q == 12'h000) begin
                    if (r_q.cmd != VWC_READ_REG) begin
                        // outputs held off by oe high before driving data
                        we_d = 1'b0; doe_d = 1'b1; do_d = r_q.data;
                    end
                end
                if (cnt_q == 12'h001) begin
                    cas_d = 1'b0;
                end
                if (cnt_q == 12'h002) begin
                    st_d = VWC_S_DATA; cnt_d = '0; oe_d = 1'b0 || (r_q.cmd != VWC_READ_REG);
                end
            end
            VWC_S_DATA: begin
                if (phase_end(cnt_q)) begin
                    if (r_q.cmd == VWC_READ_REG) begin
                        rd_d = dq_in;
                    end
                    st_d = VWC_S_PRE; cnt_d = '0;
                    doe_d = 1'b0; oe_d = 1'b1; we_d = 1'b1;
                end
            end
            VWC_S_PRE: begin
                ras_d = 1'b1; cas_d = 1'b1; fl_d = 1'b0;  // cycle type released
                if (phase_end(cnt_q)) begin
                    cnt_d = '0;
                    if (ninit_q < 4'(INIT_CYCLES)) begin
                        ninit_d = ninit_q + 4'h1;
                        if (ninit_q + 4'h1 < 4'(INIT_CYCLES)) begin
                            st_d = VWC_S_SCLK;  // another clearing refresh
                        end else begin
                            st_d = VWC_S_IDLE;
                        end
                    end else begin
                        st_d = VWC_S_IDLE; done_d = 1'b1;
                    end
                end
            end
            default: begin
                st_d = VWC_S_INIT; cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= VWC_S_INIT; cnt_q <= '0; ninit_q <= '0; r_q <= '0;
            ras_q <= 1'b1; cas_q <= 1'b1; we_q <= 1'b1; oe_q <= 1'b1; fl_q <= 1'b0;
            sc_q <= 1'b0; doe_q <= 1'b0; a_q <= ADDR_RST; do_q <= MASK_ALL;
            rd_q <= '0; done_q <= 1'b0;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; ninit_q <= ninit_d; r_q <= r_d;
            ras_q <= ras_d; cas_q <= cas_d; we_q <= we_d; oe_q <= oe_d; fl_q <= fl_d;
            sc_q <= sc_d; doe_q <= doe_d; a_q <= a_d; do_q <= do_d;
            rd_q <= rd_d; done_q <= done_d;
        end
    end

    // pins straight from flops, except the reserved flag and serial port enable, which are tied off
    assign row_strobe_n             = ras_q;
    assign col_strobe_n             = cas_q;
    assign write_enable_n           = we_q;
    assign transfer_output_enable_n = oe_q;
    assign function_flag_in         = fl_q;
    assign reserved_function_flag   = 1'b0;
    assign serial_clock             = sc_q;
    assign serial_port_enable_n     = 1'b1;  // serial port unused here
    assign addr                     = a_q;   // no split transfers issued
    assign dq_out                   = do_q;
    assign dq_oe                    = doe_q;
    assign req_ready                = (st_q == VWC_S_IDLE);
    assign done                     = done_q;
    assign rd_data                  = rd_q;
    assign init_done                = (ninit_q == 4'(INIT_CYCLES));
    // read-modify-write not issued; is the device's side
endmodule
`default_nettype wire

// ---- design/vwc_pkg.sv ----
// package for the video ram write-cycle controller
// assumes a single 25 MHz clock and an asynchronous multiport dram on the far side
`default_nettype none
package vwc_pkg;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned CLK_MHZ       = 25;
    localparam int unsigned PWRUP_US      = 100;   // least pause after power-up
    localparam int unsigned PWRUP_CYC     = PWRUP_US * CLK_MHZ;
    localparam int unsigned INIT_CYCLES   = 8;     // least initialisation cycles
    localparam int unsigned PH_CYC        = 2;     // clock cycles per serial-clock, data and precharge phase
    localparam logic [7:0]  MASK_ALL      = 8'hff;
    localparam logic [8:0]  ADDR_RST      = 9'h000;

    // cycles the user may order: writes, register loads, register read, clearing refresh
    typedef enum logic [2:0] {
        VWC_MASKED_WRITE       = 3'h0,
        VWC_MASKED_BLOCK_WRITE = 3'h1,
        VWC_PLAIN_WRITE        = 3'h2,
        VWC_PLAIN_BLOCK_WRITE  = 3'h3,
        VWC_LOAD_WRITE_MASK    = 3'h4,
        VWC_LOAD_COLOUR        = 3'h5,
        VWC_READ_REG           = 3'h6,
        VWC_REFRESH_CLEAR      = 3'h7
    } vwc_cmd_t;

    // one order from the user side
    typedef struct packed {
        vwc_cmd_t   cmd;
        logic [8:0] row;
        logic [8:0] col;
        logic [7:0] mask;      // per-bit write mask, high lets the bit through
        logic [7:0] data;      // write data, column mask or register value
        logic       new_mask;  // drive mask at row fall, else device uses stored mask
    } vwc_req_t;

    // levels sampled by the device at the two strobe falls
    typedef struct packed {
        logic flag_row;
        logic flag_col;
        logic we_row_n;
    } vwc_code_t;

    typedef enum logic [2:0] {
        VWC_S_INIT  = 3'b000,
        VWC_S_IDLE  = 3'b001,
        VWC_S_ROW   = 3'b011,
        VWC_S_COL   = 3'b010,
        VWC_S_DATA  = 3'b110,
        VWC_S_PRE   = 3'b111,
        VWC_S_SCLK  = 3'b101
    } vwc_state_t;
endpackage
`default_nettype wire

// ---- design/vwc_code_rom.sv ----
// strobe-level lookup for each cycle type
// registered output, as the memory style asks; latency one clock
`default_nettype none
module vwc_code_rom (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // lookup
    input  wire vwc_pkg::vwc_cmd_t cmd,
    output var  vwc_pkg::vwc_code_t code
);
    timeunit 1ns;
    timeprecision 1ns;
    import vwc_pkg::*;
    vwc_code_t code_d;

    // flag at row fall, flag at column fall, write enable at row fall
    always_comb begin
        case (cmd)
            VWC_MASKED_WRITE:       code_d = '{1'b0, 1'b0, 1'b0};
            VWC_MASKED_BLOCK_WRITE: code_d = '{1'b0, 1'b1, 1'b0};
            VWC_PLAIN_WRITE:        code_d = '{1'b0, 1'b0, 1'b1};
            VWC_PLAIN_BLOCK_WRITE:  code_d = '{1'b0, 1'b1, 1'b1};
            VWC_LOAD_WRITE_MASK:    code_d = '{1'b1, 1'b0, 1'b1};
            VWC_LOAD_COLOUR:        code_d = '{1'b1, 1'b1, 1'b1};
            VWC_READ_REG:           code_d = '{1'b1, 1'b0, 1'b1};
            default:                code_d = '{1'b0, 1'b0, 1'b1};
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            code <= '0;
        end else begin
            code <= code_d;
        end
    end
endmodule
`default_nettype wire

// ---- tb/vwc_ctrl_sva.sv ----
// assertions on the ram-port pins and user handshake of vwc_ctrl
// assumes one sys_clk domain; bound to every vwc_ctrl instance
`default_nettype none
module vwc_ctrl_sva (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // user side
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       done,
    input wire logic       init_done,
    // dram pins
    input wire logic       row_strobe_n,
    input wire logic       col_strobe_n,
    input wire logic       write_enable_n,
    input wire logic       transfer_output_enable_n,
    input wire logic       function_flag_in,
    input wire logic       reserved_function_flag,
    input wire logic       serial_clock,
    input wire logic [8:0] addr,
    input wire logic       dq_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] fall_cnt_q, fall_cnt_d;
    logic       sc_q, sc_d, ras_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // row falls and serial pulse before init ends; saturates so it cannot wrap
    always_comb begin
        fall_cnt_d = fall_cnt_q;
        if (ras_q && !row_strobe_n && fall_cnt_q != 4'hf) fall_cnt_d = fall_cnt_q + 4'h1;
        sc_d = sc_q | serial_clock;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fall_cnt_q <= 4'h0;
            sc_q <= 1'b0;
            ras_q <= 1'b1;
        end else begin
            fall_cnt_q <= fall_cnt_d;
            sc_q <= sc_d;
            ras_q <= row_strobe_n;
        end
    end
    a_rsv_flag_low: assert property (reserved_function_flag == 1'b0)
        else $error("reserved flag not low");
    a_init_count: assert property ($rose(init_done) |-> fall_cnt_q >= 4'h8)
        else $error("too few init cycles");
    a_init_sclk: assert property ($rose(init_done) |-> sc_q)
        else $error("no serial clock before ready");
    a_init_refresh: assert property (!init_done && $fell(row_strobe_n) |->
        !col_strobe_n && write_enable_n && !function_flag_in) else $error("init not cbr clear");
    a_early_write: assert property (init_done && $fell(col_strobe_n) && dq_oe |->
        $past(write_enable_n) == 1'b0) else $error("write not early");
    a_dq_released: assert property (!transfer_output_enable_n |-> !dq_oe)
        else $error("data driven while device outputs on");
    a_row_held: assert property (init_done && col_strobe_n && $fell(row_strobe_n) |->
        !row_strobe_n [*4] ##[1:12] row_strobe_n) else $error("row strobe cycle length");
    a_cbr_held: assert property (init_done && !col_strobe_n && $fell(row_strobe_n) |->
        !row_strobe_n ##[1:4] row_strobe_n) else $error("refresh row strobe length");
    a_done_in_time: assert property (req_valid && req_ready ##1 col_strobe_n |->
        ##[7:15] done) else $error("done late");
    a_refresh_done: assert property (req_valid && req_ready ##1 !col_strobe_n |->
        ##[3:5] done) else $error("refresh done late");
    a_col_setup: assert property (init_done && !row_strobe_n && $fell(col_strobe_n) |->
        $stable(function_flag_in) && $stable(addr)) else $error("flag or addr moved at col fall");
endmodule
bind vwc_ctrl vwc_ctrl_sva vwc_ctrl_sva_i (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .done(done), .init_done(init_done), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
    .transfer_output_enable_n(transfer_output_enable_n), .function_flag_in(function_flag_in),
    .reserved_function_flag(reserved_function_flag), .serial_clock(serial_clock),
    .addr(addr), .dq_oe(dq_oe));
`default_nettype wire

// ---- tb/vwc_dev_model.sv ----
// behavioural video dram ram port: cycle decode, masks, colour, block write
// assumes strobes from vwc_ctrl; memory indexed by column only to stay small
`default_nettype none
module vwc_dev_model #(
    parameter logic [7:0] MASK_RST = 8'hff
) (
    // strobes and flags
    input wire logic       row_strobe_n,
    input wire logic       col_strobe_n,
    input wire logic       write_enable_n,
    input wire logic       transfer_output_enable_n,
    input wire logic       function_flag_in,
    input wire logic       serial_clock,
    // address and data
    input wire logic [8:0] addr,
    input wire logic [7:0] dq_out,
    input wire logic       dq_oe,
    output logic [7:0]     dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:511];
    logic [7:0] mask_reg = MASK_RST, colour_reg = 8'h00, row_mask, last = 8'h00;
    logic [8:0] col;
    logic       flag_row, flag_col = 1'b0, we_row_n, persist = 1'b0, sc_seen = 1'b0;
    int         refresh_cnt = 0, xfer_cnt = 0;
    // a released bus shows the inverse of its last value, never a stale copy
    wire logic [7:0] bus = dq_oe ? dq_out : ~last;
    wire logic rd_on = !row_strobe_n && !col_strobe_n && !transfer_output_enable_n;
    assign dq_in = rd_on ? (flag_col ? colour_reg : mask_reg) : ~last;
    always @* if (dq_oe) last = dq_out;
    initial for (int i = 0; i < 512; i++) mem[i] = 8'h00;
    always @(posedge serial_clock) sc_seen = 1'b1;
    // cycle decode at row fall; cbr with we high and flag low clears the mask state
    always @(negedge row_strobe_n) begin
        if (!col_strobe_n) begin
            refresh_cnt++;
            if (write_enable_n && !function_flag_in) persist = 1'b0;
            if (write_enable_n && !function_flag_in) mask_reg = MASK_RST;
        end else begin
            flag_row = function_flag_in;
            // output enable low at row fall would start a transfer, never wanted here
            if (!transfer_output_enable_n) xfer_cnt++;
            we_row_n = write_enable_n;
            row_mask = persist ? mask_reg : bus;
        end
    end
    // data latched at the later of column fall and write-enable fall
    always @(negedge col_strobe_n) if (!row_strobe_n) begin
        flag_col = function_flag_in;
        col = addr;  // no split transfers reach this model, top bit kept
        if (!write_enable_n) do_write(bus);
    end
    // late write-enable fall: delayed or read-modify-write data latched here
    always @(negedge write_enable_n) if (!row_strobe_n && !col_strobe_n) do_write(bus);
    task automatic do_write(input logic [7:0] d);
        logic [7:0] wm;
        wm = we_row_n ? 8'hff : row_mask;
        if (flag_row && flag_col) colour_reg = d;
        else if (flag_row) mask_reg = d;
        if (flag_row && !flag_col) persist = 1'b1;
        if (!flag_row && !flag_col) mem[col] = (mem[col] & ~wm) | (d & wm);
        // block of four columns, a width chosen for this model
        if (!flag_row && flag_col) for (int i = 0; i < 4; i++) if (d[i])
            mem[{col[8:2], 2'(i)}] = (mem[{col[8:2], 2'(i)}] & ~wm) | (colour_reg & wm);
    endtask
endmodule
`default_nettype wire

// ---- tb/vwc_ctrl_tb.sv ----
// self-checking bench: vwc_ctrl driving the behavioural video dram model
// assumes a 25 MHz clock and a shortened power-up pause
`default_nettype none
module vwc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import vwc_pkg::*;
    logic sys_clk, nrst, req_valid, req_ready, done, init_done, ras_n, cas_n, we_n, oe_n;
    logic ff_in, ff_rsv, sclk, sen_n, dq_oe;
    logic [7:0] rd_data, dq_in, dq_out;
    logic [8:0] addr;
    vwc_req_t   req;
    int err_count = 0, compares = 0, cyc = 0;
    vwc_ctrl #(.PWRUP_CYCLES(10)) vwc_ctrl_i (.sys_clk(sys_clk), .nrst(nrst),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done), .rd_data(rd_data),
        .init_done(init_done), .row_strobe_n(ras_n), .col_strobe_n(cas_n), .write_enable_n(we_n),
        .transfer_output_enable_n(oe_n), .function_flag_in(ff_in), .reserved_function_flag(ff_rsv),
        .serial_clock(sclk), .serial_port_enable_n(sen_n), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));
    vwc_dev_model vwc_dev_model_i (.row_strobe_n(ras_n), .col_strobe_n(cas_n),
        .write_enable_n(we_n), .transfer_output_enable_n(oe_n), .function_flag_in(ff_in),
        .serial_clock(sclk), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            $display("CHECK FAILED t=%0t timeout", $time);
            summarize();
        end
    end
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one order: wait for ready, hold valid over the taking edge, wait for done
    task automatic issue(input vwc_cmd_t c, input logic [8:0] cl, input logic [7:0] m,
                         input logic [7:0] d, input logic nm);
        int n;
        for (n = 0; req_ready !== 1'b1 && n < 50; n++) step();
        req = '{cmd: c, row: 9'h003, col: cl, mask: m, data: d, new_mask: nm};
        req_valid = 1'b1;
        step();
        req_valid = 1'b0;
        for (n = 0; done !== 1'b1 && n < 50; n++) step();
        chk({7'h00, done}, 8'h01, "done missing");
    endtask
    task automatic t_init();
        int n;
        for (n = 0; init_done !== 1'b1 && n < 400; n++) step();
        chk({7'h00, init_done}, 8'h01, "init not finished");
        chk({7'h00, vwc_dev_model_i.sc_seen}, 8'h01, "no serial clock");
        chk({7'h00, vwc_dev_model_i.refresh_cnt >= 8}, 8'h01, "too few init cycles");
    endtask
    task automatic t_writes();
        issue(VWC_PLAIN_WRITE, 9'h005, 8'h00, 8'ha5, 1'b0);
        chk(vwc_dev_model_i.mem[5], 8'ha5, "plain write");
        issue(VWC_MASKED_WRITE, 9'h005, 8'h0f, 8'h5a, 1'b1);
        chk(vwc_dev_model_i.mem[5], 8'haa, "masked write");
    endtask
    task automatic t_block();
        issue(VWC_LOAD_COLOUR, 9'h1ff, 8'h00, 8'hc3, 1'b0);
        issue(VWC_PLAIN_BLOCK_WRITE, 9'h008, 8'h00, 8'h05, 1'b0);
        chk(vwc_dev_model_i.mem[8], 8'hc3, "block col 0");
        chk(vwc_dev_model_i.mem[9], 8'h00, "block col 1 kept");
        chk(vwc_dev_model_i.mem[10], 8'hc3, "block col 2");
        issue(VWC_MASKED_BLOCK_WRITE, 9'h00c, 8'h0f, 8'h01, 1'b1);
        chk(vwc_dev_model_i.mem[12], 8'h03, "masked block");
    endtask
    task automatic t_regs();
        issue(VWC_LOAD_WRITE_MASK, 9'h000, 8'h00, 8'h3c, 1'b0);
        issue(VWC_MASKED_WRITE, 9'h006, 8'h00, 8'hff, 1'b0);
        chk(vwc_dev_model_i.mem[6], 8'h3c, "persistent mask");
        issue(VWC_READ_REG, 9'h000, 8'h00, 8'h00, 1'b0);
        chk(rd_data, 8'h3c, "register read");
        chk({7'h00, vwc_dev_model_i.flag_col}, 8'h00, "read flag at column fall");
        chk(8'(vwc_dev_model_i.xfer_cnt), 8'h00, "transfer decoded at row fall");
        issue(VWC_REFRESH_CLEAR, 9'h000, 8'h00, 8'h00, 1'b0);
        chk({7'h00, vwc_dev_model_i.persist}, 8'h00, "mask state not cleared");
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (12) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        t_init();
        t_writes();
        t_block();
        t_regs();
        summarize();
    end
endmodule
`default_nettype wire
